/* File: design/sarc_pkg.sv */
package sarc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_CONFIG     = 8'h04;
  localparam logic [7:0] OFS_SAMP_TIME  = 8'h08;
  localparam logic [7:0] OFS_SAMP_SEL   = 8'h0c;
  localparam logic [7:0] OFS_STATUS     = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_RESULT     = 8'h18;
  localparam logic [7:0] OFS_WATCH_CH   = 8'h1c;
  localparam logic [7:0] OFS_WATCH_THR  = 8'h20;
  // control bits (write one)
  localparam int CTL_START = 0;
  localparam int CTL_STOP  = 1;
  // config bits
  localparam int CFG_LOW_FREQ  = 0;
  localparam int CFG_OVR_POL   = 1;
  localparam int CFG_DMA_EN    = 2;
  localparam int CFG_AUTO_WAIT = 3;
  localparam int CFG_TEMP_EN   = 4;
  localparam int CFG_CH_LSB    = 16;
  localparam int CFG_CH_MSB    = 20;
  // status bits, irq enables share the flag positions
  localparam int ST_DONE    = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_ALERT   = 2;
  localparam int ST_BUSY    = 3;
  localparam int ST_ARMED   = 4;
  // sampling time fields
  localparam int SAMP_A_LSB = 0;
  localparam int SAMP_A_MSB = 3;
  localparam int SAMP_B_LSB = 4;
  localparam int SAMP_B_MSB = 7;
  // threshold fields
  localparam int THR_LO_LSB = 0;
  localparam int THR_LO_MSB = 11;
  localparam int THR_HI_LSB = 16;
  localparam int THR_HI_MSB = 27;
  // widths and timing
  localparam int NUM_CH   = 20;
  localparam int DATA_W   = 12;
  localparam logic [3:0] SAR_CYCLES   = 4'h000d;
  localparam logic [3:0] SAMP_MIN     = 4'h0001;
  localparam logic [NUM_CH-1:0] WATCH_CH_MASK = 20'h9_ffff;
  localparam logic [4:0] TEMP_CHANNEL = 5'h0c;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  // conversion sequencer
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_RESET  = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_SAR    = 2'b11
  } sarc_state_e;
endpackage : sarc_pkg

/* File: design/sarc_top.sv */
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
// How it works
// - low-freq mode resets converter on each trigger
// - conversion is sampling then 13 sar cycles
// - two 4-bit sampling times set sample length
// - per-channel bit picks sampling time a/b
// - completion with done still set sets overrun
// - overrun cleared by write one, raises irq
// - after overrun keep converting; stop halts
// - preserve policy keeps old result, drops new
// - overwrite policy always stores latest result
// - completion sets done and updates result unless the new one is dropped
// - dma enabled: one request per conversion that ends without overrun
// - overrun under either policy stops dma requests
// - auto-wait: no new conversion until result taken
// - auto-wait: hardware triggers ignored while waiting
// - watchdog only on enabled channels 0-16, 19
// - compare 12-bit result to both thresholds
// - out of range sets alert, irq, write-one clear
// - threshold write mid conversion masks that result
// - temp sensor enable powers sensor on channel 12
// - done cleared by write one or result read
// - triggers during conversion are ignored
module sarc_top (
  input  wire logic        ref_clk_in,         // 20 MHz clock
  input  wire logic        reset_in,           // async reset, high
  input  wire logic        psel_in,            // apb select
  input  wire logic        penable_in,         // apb enable
  input  wire logic        pwrite_in,          // apb direction
  input  wire logic [7:0]  paddr_in,           // apb byte address
  input  wire logic [31:0] pwdata_in,          // apb write data
  output logic      [31:0] prdata_out,         // apb read data
  output logic             pready_out,         // apb ready
  output logic             pslverr_out,        // apb error, unmapped
  input  wire logic        hw_trigger_in,      // hardware trigger pulse
  input  wire logic [11:0] sar_data_in,        // converter result
  output logic             analog_reset_out,   // converter state reset
  output logic             sample_hold_out,    // sampling phase
  output logic             sar_active_out,     // approximation phase
  output logic      [4:0]  channel_out,        // selected input
  output logic             temp_sensor_power_out, // sensor power
  output logic             dma_req_out,        // one-cycle dma request
  output logic             irq_out             // interrupt level
);

  // register file and sequencer state
  sarc_pkg::sarc_state_e state_ff,      nxt_state;
  logic [3:0]            cnt_ff,        nxt_cnt;
  logic [31:0]           cfg_ff,        nxt_cfg;
  logic [7:0]            samp_ff,       nxt_samp;
  logic [19:0]           sel_ff,        nxt_sel;
  logic [19:0]           wch_ff,        nxt_wch;
  logic [31:0]           thr_ff,        nxt_thr;
  logic [2:0]            ier_ff,        nxt_ier;
  logic                  armed_ff,      nxt_armed;
  logic                  done_ff,       nxt_done;
  logic                  overrun_ff,    nxt_overrun;
  logic                  alert_ff,      nxt_alert;
  logic                  mask_ff,       nxt_mask;
  logic [11:0]           result_ff,     nxt_result;
  logic [31:0]           prdata_ff,     nxt_prdata;
  logic                  pready_ff,     nxt_pready;
  logic                  pslverr_ff,    nxt_pslverr;
  logic                  dma_ff,        nxt_dma;
  logic                  irq_ff,        nxt_irq;
  logic                  areset_ff,     nxt_areset;

  logic       setup, access, wr, ctl_wr, stop_wr, sw_trig, go, conv_end;
  logic       ovr_evt, store, monitored, thr_wr, out_range, policy;
  logic [3:0] samp_len;
  logic [4:0] chan;

  // true for addresses that hold a register
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      sarc_pkg::OFS_CONTROL, sarc_pkg::OFS_CONFIG,
      sarc_pkg::OFS_SAMP_TIME, sarc_pkg::OFS_SAMP_SEL,
      sarc_pkg::OFS_STATUS, sarc_pkg::OFS_IRQ_ENABLE,
      sarc_pkg::OFS_RESULT, sarc_pkg::OFS_WATCH_CH,
      sarc_pkg::OFS_WATCH_THR: is_mapped = 1'b1;
      default:                 is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // decode of a write to one address in the access phase
  function automatic logic wr_hit(input logic       w,
                                  input logic [7:0] a,
                                  input logic [7:0] ofs);
    wr_hit = w && (a == ofs);
  endfunction : wr_hit

  // bus phases: ready answers one cycle after setup
  assign setup   = psel_in && !penable_in;
  assign access  = psel_in && penable_in && pready_ff;
  assign wr      = access && pwrite_in;
  assign ctl_wr  = wr_hit(wr, paddr_in, sarc_pkg::OFS_CONTROL);
  assign stop_wr = ctl_wr && pwdata_in[sarc_pkg::CTL_STOP];
  assign sw_trig = ctl_wr && pwdata_in[sarc_pkg::CTL_START];
  assign thr_wr  = wr_hit(wr, paddr_in, sarc_pkg::OFS_WATCH_THR);
  assign policy  = cfg_ff[sarc_pkg::CFG_OVR_POL];
  assign chan    = cfg_ff[sarc_pkg::CFG_CH_MSB:sarc_pkg::CFG_CH_LSB];

  // only an idle, unblocked sequencer accepts a trigger
  assign go = (sw_trig || (armed_ff && hw_trigger_in))
           && (state_ff == sarc_pkg::ST_IDLE)
           && !(cfg_ff[sarc_pkg::CFG_AUTO_WAIT] && done_ff)
           && !stop_wr;

  // sample length from the channel's chosen setting, never zero
  always_comb begin
    samp_len = sel_ff[chan] ? samp_ff[sarc_pkg::SAMP_B_MSB:
                                      sarc_pkg::SAMP_B_LSB]
                            : samp_ff[sarc_pkg::SAMP_A_MSB:
                                      sarc_pkg::SAMP_A_LSB];
    if (samp_len < sarc_pkg::SAMP_MIN) begin
      samp_len = sarc_pkg::SAMP_MIN;
    end
  end

  // end of conversion and what it does with the new result
  assign conv_end  = (state_ff == sarc_pkg::ST_SAR)
                  && (cnt_ff == sarc_pkg::SAMP_MIN);
  assign ovr_evt   = conv_end && done_ff;
  assign store     = conv_end && (policy ||
                     (!done_ff && !overrun_ff));
  assign monitored = wch_ff[chan]
                  && sarc_pkg::WATCH_CH_MASK[chan];
  assign out_range = (sar_data_in < thr_ff[sarc_pkg::THR_LO_MSB:
                                           sarc_pkg::THR_LO_LSB])
                  || (sar_data_in > thr_ff[sarc_pkg::THR_HI_MSB:
                                           sarc_pkg::THR_HI_LSB]);

  // sequencer next state
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_areset = 1'b0;
    case (state_ff)
      sarc_pkg::ST_IDLE: begin
        if (go && cfg_ff[sarc_pkg::CFG_LOW_FREQ]) begin
          nxt_state  = sarc_pkg::ST_RESET;
          nxt_areset = 1'b1;
        end else if (go) begin
          nxt_state = sarc_pkg::ST_SAMPLE;
          nxt_cnt   = samp_len;
        end
      end
      sarc_pkg::ST_RESET: begin
        nxt_state = sarc_pkg::ST_SAMPLE;
        nxt_cnt   = samp_len;
      end
      sarc_pkg::ST_SAMPLE: begin
        if (cnt_ff == sarc_pkg::SAMP_MIN) begin
          nxt_state = sarc_pkg::ST_SAR;
          nxt_cnt   = sarc_pkg::SAR_CYCLES;
        end else begin
          nxt_cnt = cnt_ff - sarc_pkg::SAMP_MIN;
        end
      end
      sarc_pkg::ST_SAR: begin
        if (conv_end) begin
          nxt_state = sarc_pkg::ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - sarc_pkg::SAMP_MIN;
        end
      end
      default: nxt_state = sarc_pkg::ST_IDLE;
    endcase
    // stop aborts and discards the conversion in flight
    if (stop_wr) begin
      nxt_state = sarc_pkg::ST_IDLE;
    end
  end

  // registers, flags, results and bus answers
  always_comb begin
    nxt_cfg     = cfg_ff;
    nxt_samp    = samp_ff;
    nxt_sel     = sel_ff;
    nxt_wch     = wch_ff;
    nxt_thr     = thr_ff;
    nxt_ier     = ier_ff;
    nxt_armed   = armed_ff;
    nxt_result  = result_ff;
    nxt_prdata  = prdata_ff;
    nxt_pready  = setup;
    nxt_pslverr = setup && !is_mapped(paddr_in);
    if (wr_hit(wr, paddr_in, sarc_pkg::OFS_CONFIG)) nxt_cfg = pwdata_in;
    if (wr_hit(wr, paddr_in, sarc_pkg::OFS_SAMP_TIME)) begin
      nxt_samp = pwdata_in[7:0];
    end
    if (wr_hit(wr, paddr_in, sarc_pkg::OFS_SAMP_SEL)) begin
      nxt_sel = pwdata_in[19:0];
    end
    if (wr_hit(wr, paddr_in, sarc_pkg::OFS_WATCH_CH)) begin
      nxt_wch = pwdata_in[19:0] & sarc_pkg::WATCH_CH_MASK;
    end
    if (thr_wr) nxt_thr = pwdata_in;
    if (wr_hit(wr, paddr_in, sarc_pkg::OFS_IRQ_ENABLE)) begin
      nxt_ier = pwdata_in[2:0];
    end
    // start arms hardware triggers, stop disarms
    if (sw_trig) nxt_armed = 1'b1;
    if (stop_wr) nxt_armed = 1'b0;
    if (store)   nxt_result = sar_data_in;
    // flags: the hardware set wins over a software clear
    nxt_done    = done_ff;
    nxt_overrun = overrun_ff;
    nxt_alert   = alert_ff;
    if ((wr_hit(wr, paddr_in, sarc_pkg::OFS_STATUS)
         && pwdata_in[sarc_pkg::ST_DONE])
        || (access && !pwrite_in
            && (paddr_in == sarc_pkg::OFS_RESULT))) begin
      nxt_done = 1'b0;
    end
    if (wr_hit(wr, paddr_in, sarc_pkg::OFS_STATUS)) begin
      if (pwdata_in[sarc_pkg::ST_OVERRUN]) nxt_overrun = 1'b0;
      if (pwdata_in[sarc_pkg::ST_ALERT])   nxt_alert   = 1'b0;
    end
    if (conv_end) nxt_done = 1'b1;
    if (ovr_evt)  nxt_overrun = 1'b1;
    if (conv_end && monitored && !mask_ff && !thr_wr && out_range) begin
      nxt_alert = 1'b1;
    end
    // watchdog mask: set by a guarded mid-conversion write
    nxt_mask = mask_ff;
    if (go) nxt_mask = 1'b0;
    if (thr_wr && monitored && (state_ff != sarc_pkg::ST_IDLE)) begin
      nxt_mask = 1'b1;
    end
    // dma held off while an overrun stands, resumes once cleared
    nxt_dma = conv_end && cfg_ff[sarc_pkg::CFG_DMA_EN]
           && !ovr_evt && !overrun_ff;
    nxt_irq = (nxt_overrun && ier_ff[sarc_pkg::ST_OVERRUN])
           || (nxt_alert && ier_ff[sarc_pkg::ST_ALERT]);
    // read data is prepared in the setup cycle
    if (setup) begin
      case (paddr_in)
        sarc_pkg::OFS_CONFIG:     nxt_prdata = cfg_ff;
        sarc_pkg::OFS_SAMP_TIME:  nxt_prdata = {24'h00_0000, samp_ff};
        sarc_pkg::OFS_SAMP_SEL:   nxt_prdata = {12'h000, sel_ff};
        sarc_pkg::OFS_WATCH_CH:   nxt_prdata = {12'h000, wch_ff};
        sarc_pkg::OFS_WATCH_THR:  nxt_prdata = thr_ff;
        sarc_pkg::OFS_IRQ_ENABLE: nxt_prdata = {29'h0000_0000, ier_ff};
        sarc_pkg::OFS_RESULT:     nxt_prdata = {20'h0_0000, result_ff};
        sarc_pkg::OFS_STATUS: begin
          nxt_prdata = sarc_pkg::RST_WORD;
          nxt_prdata[sarc_pkg::ST_DONE]    = done_ff;
          nxt_prdata[sarc_pkg::ST_OVERRUN] = overrun_ff;
          nxt_prdata[sarc_pkg::ST_ALERT]   = alert_ff;
          nxt_prdata[sarc_pkg::ST_BUSY]    = state_ff != sarc_pkg::ST_IDLE;
          nxt_prdata[sarc_pkg::ST_ARMED]   = armed_ff;
        end
        default: nxt_prdata = sarc_pkg::RST_WORD;
      endcase
    end
  end

  // all state registered here, constants only under reset
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff   <= sarc_pkg::ST_IDLE;
      cnt_ff     <= 4'h0;
      cfg_ff     <= sarc_pkg::RST_WORD;
      samp_ff    <= 8'h00;
      sel_ff     <= 20'h0_0000;
      wch_ff     <= 20'h0_0000;
      thr_ff     <= sarc_pkg::RST_WORD;
      ier_ff     <= 3'h0;
      armed_ff   <= 1'b0;
      done_ff    <= 1'b0;
      overrun_ff <= 1'b0;
      alert_ff   <= 1'b0;
      mask_ff    <= 1'b0;
      result_ff  <= 12'h000;
      prdata_ff  <= sarc_pkg::RST_WORD;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      dma_ff     <= 1'b0;
      irq_ff     <= 1'b0;
      areset_ff  <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      cfg_ff     <= nxt_cfg;
      samp_ff    <= nxt_samp;
      sel_ff     <= nxt_sel;
      wch_ff     <= nxt_wch;
      thr_ff     <= nxt_thr;
      ier_ff     <= nxt_ier;
      armed_ff   <= nxt_armed;
      done_ff    <= nxt_done;
      overrun_ff <= nxt_overrun;
      alert_ff   <= nxt_alert;
      mask_ff    <= nxt_mask;
      result_ff  <= nxt_result;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      dma_ff     <= nxt_dma;
      irq_ff     <= nxt_irq;
      areset_ff  <= nxt_areset;
    end
  end

  // outputs straight from flops; phase strobes decode the state
  assign prdata_out            = prdata_ff;
  assign pready_out            = pready_ff;
  assign pslverr_out           = pslverr_ff;
  assign analog_reset_out      = areset_ff;
  assign sample_hold_out       = state_ff == sarc_pkg::ST_SAMPLE;
  assign sar_active_out        = state_ff == sarc_pkg::ST_SAR;
  assign channel_out           = chan;
  assign temp_sensor_power_out = cfg_ff[sarc_pkg::CFG_TEMP_EN];
  assign dma_req_out           = dma_ff;
  assign irq_out               = irq_ff;

  // checks
  property p_sar_len;
    @(posedge ref_clk_in) disable iff (reset_in || stop_wr)
    $rose(sar_active_out) |-> sar_active_out[*8] ##0
      (sar_active_out[*6] or !sar_active_out[*1]);
  endproperty
  a_sar_len: assert property (p_sar_len) else $error("sar phase length");
  property p_sar_exact;
    @(posedge ref_clk_in) disable iff (reset_in)
    conv_end |-> $past(sar_active_out, 12) && !$past(sar_active_out, 13);
  endproperty
  a_sar_exact: assert property (p_sar_exact) else $error("sar not 13");
  property p_ovr_set;
    @(posedge ref_clk_in) disable iff (reset_in)
    conv_end && done_ff |=> overrun_ff && done_ff;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun missed");
  property p_keep_data;
    @(posedge ref_clk_in) disable iff (reset_in)
    conv_end && !policy && (done_ff || overrun_ff) |=> $stable(result_ff);
  endproperty
  a_keep_data: assert property (p_keep_data) else $error("data lost");
  property p_overwrite;
    @(posedge ref_clk_in) disable iff (reset_in)
    conv_end && policy |=> result_ff == $past(sar_data_in);
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("no overwrite");
  property p_dma_req;
    @(posedge ref_clk_in) disable iff (reset_in)
    conv_end && cfg_ff[sarc_pkg::CFG_DMA_EN] && !done_ff && !overrun_ff
      |=> dma_req_out ##1 !dma_req_out;
  endproperty
  a_dma_req: assert property (p_dma_req) else $error("dma request");
  property p_dma_block;
    @(posedge ref_clk_in) disable iff (reset_in)
    conv_end && (done_ff || overrun_ff) |=> !dma_req_out;
  endproperty
  a_dma_block: assert property (p_dma_block) else $error("dma not held");
  property p_auto_wait;
    @(posedge ref_clk_in) disable iff (reset_in)
    cfg_ff[sarc_pkg::CFG_AUTO_WAIT] && done_ff
      && state_ff == sarc_pkg::ST_IDLE |=> state_ff == sarc_pkg::ST_IDLE;
  endproperty
  a_auto_wait: assert property (p_auto_wait) else $error("wait broken");
  property p_low_freq;
    @(posedge ref_clk_in) disable iff (reset_in)
    go && cfg_ff[sarc_pkg::CFG_LOW_FREQ] |=> analog_reset_out ##1
      sample_hold_out;
  endproperty
  a_low_freq: assert property (p_low_freq) else $error("no reset");
  property p_busy_ignore;
    @(posedge ref_clk_in) disable iff (reset_in)
    sample_hold_out && !stop_wr |=> !analog_reset_out;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("retrigger");
  property p_mask;
    @(posedge ref_clk_in) disable iff (reset_in)
    mask_ff && conv_end |=> $stable(alert_ff) || !alert_ff;
  endproperty
  a_mask: assert property (p_mask) else $error("masked alert set");
  c_overrun: cover property (@(posedge ref_clk_in) ovr_evt);
  c_alert: cover property (@(posedge ref_clk_in) $rose(alert_ff));
  c_dma: cover property (@(posedge ref_clk_in) dma_req_out);
  c_stop: cover property (@(posedge ref_clk_in) stop_wr && sar_active_out);

endmodule : sarc_top

/* File: verif/sarc_conv_model.sv */
`timescale 1ns/1ps
// stand-in for the analog converter that feeds the result lines
module sarc_conv_model (
  input  wire logic        ref_clk_in,    // converter clock
  input  wire logic        reset_in,      // async reset, high
  input  wire logic        sar_active_in, // approximation phase
  input  wire logic [11:0] level_in,      // value to report
  output logic      [11:0] sar_data_out   // result lines
);
  logic [11:0] last_ff;
  // lines churn outside the phase so a mistimed sample shows up
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      last_ff <= 12'h000;
    end else begin
      last_ff <= sar_active_in ? level_in : ~last_ff;
    end
  end
  assign sar_data_out = sar_active_in ? level_in : last_ff;
endmodule : sarc_conv_model

/* File: verif/sarc_top_bench.sv */
`timescale 1ns/1ps
module sarc_top_bench;
  typedef struct {logic [31:0] e; logic [31:0] m; logic s;} sarc_exp_s;
  logic        ref_clk_in = 1'h0;
  logic        reset_in   = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, hw_trig = 1'h0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [11:0] level  = 12'h000;
  logic [31:0] prdata;
  logic [11:0] sar_data, v;
  logic        pready, pslverr, arst, samp, sar, temp_pwr, dma, irq;
  logic        samp_q = 1'h0, sar_q = 1'h0;
  logic [4:0]  chan;
  logic [3:0]  ta, tb, t;
  int          err_total = 0, num_checks = 0, cyc = 0, k, c0, d0;
  int          run_s = 0, run_r = 0, n_conv = 0, n_dma = 0, n_arst = 0;
  sarc_exp_s   expq[$];
  sarc_exp_s   x;

  sarc_top dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .hw_trigger_in(hw_trig),
    .sar_data_in(sar_data), .analog_reset_out(arst),
    .sample_hold_out(samp), .sar_active_out(sar), .channel_out(chan),
    .temp_sensor_power_out(temp_pwr), .dma_req_out(dma), .irq_out(irq));
  sarc_conv_model conv_model (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .sar_active_in(sar), .level_in(level), .sar_data_out(sar_data));

  // free running clock, 50 ns period
  always #25 ref_clk_in = ~ref_clk_in;

  task results;
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (e !== s) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // one apb transfer; a read leaves its expectation for the watcher
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] m, input logic s);
    int i;
    if (!w) expq.push_back('{d, m, s});
    @(posedge ref_clk_in);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0000_0000;
    @(posedge ref_clk_in);
    penable <= 1'h1;
    @(posedge ref_clk_in);
    for (i = 0; i < 50 && pready !== 1'h1; i++) @(posedge ref_clk_in);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 32'h0000_0000, 1'h0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'h0, a, e, m, a > sarc_pkg::OFS_WATCH_THR);
  endtask : rd

  task pulse;
    @(posedge ref_clk_in);
    hw_trig <= 1'h1;
    @(posedge ref_clk_in);
    hw_trig <= 1'h0;
  endtask : pulse

  task wait_conv;
    int i;
    c0 = n_conv;
    for (i = 0; i < 300 && n_conv == c0; i++) @(posedge ref_clk_in);
    repeat (2) @(posedge ref_clk_in);
  endtask : wait_conv

  // a second start lands while busy and must not add a conversion
  task conv(input logic [11:0] val);
    level <= val;
    wr(sarc_pkg::OFS_CONTROL, 32'h0000_0001);
    wr(sarc_pkg::OFS_CONTROL, 32'h0000_0001);
    wait_conv;
    repeat (40) @(posedge ref_clk_in);
    chk("conversions", c0 + 1, n_conv);
  endtask : conv

  task wconv(input logic [11:0] val, input logic a);
    conv(val);
    rd(sarc_pkg::OFS_STATUS, {29'h0, a, 2'h0}, 32'h0000_0004);
    chk("irq", {31'h0, a}, {31'h0, irq});
    wr(sarc_pkg::OFS_STATUS, 32'h0000_0004);
    rd(sarc_pkg::OFS_RESULT, {20'h0_0000, val}, 32'h0000_0fff);
  endtask : wconv

  // watcher: phase lengths, pulse counts, read answers, hang limit
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    samp_q <= samp;
    sar_q <= sar;
    if (samp) run_s <= samp_q ? run_s + 1 : 1;
    if (sar) run_r <= sar_q ? run_r + 1 : 1;
    if (sar_q && !sar) n_conv <= n_conv + 1;
    if (dma) n_dma <= n_dma + 1;
    if (arst) n_arst <= n_arst + 1;
    if (psel && penable && pready === 1'h1 && !pwrite) begin
      x = expq.pop_front();
      chk("prdata", x.e & x.m, prdata & x.m);
      chk("pslverr", {31'h0, x.s}, {31'h0, pslverr});
    end
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  initial begin
    void'($urandom(64139));
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'h0;
    rd(sarc_pkg::OFS_STATUS, 32'h0000_0000, 32'hffff_ffff);
    rd(8'h30, 32'h0000_0000, 32'hffff_ffff);
    ta = 4'($urandom);
    tb = 4'($urandom);
    wr(sarc_pkg::OFS_SAMP_TIME, {24'h00_0000, tb, ta});
    wr(sarc_pkg::OFS_SAMP_SEL, 32'h0000_0020);
    wr(sarc_pkg::OFS_IRQ_ENABLE, 32'h0000_0006);
    for (k = 0; k < 2; k++) begin
      wr(sarc_pkg::OFS_CONFIG, k ? 32'h0005_0000 : 32'h0004_0000);
      v = 12'($urandom);
      t = k ? tb : ta;
      conv(v);
      chk("sample", (t == 4'h0) ? 32'h1 : {28'h0, t}, run_s);
      chk("sar", 32'h0000_000d, run_r);
      rd(sarc_pkg::OFS_RESULT, {20'h0_0000, v}, 32'h0000_0fff);
      rd(sarc_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0001);
    end
    // keep-old policy: second result is dropped
    conv(12'h0a1);
    conv(12'h0b2);
    rd(sarc_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0007);
    chk("irq", 32'h1, {31'h0, irq});
    conv(12'h0c3);
    rd(sarc_pkg::OFS_RESULT, 32'h0000_00a1, 32'h0000_0fff);
    wr(sarc_pkg::OFS_STATUS, 32'h0000_0002);
    repeat (2) @(posedge ref_clk_in);
    chk("irq", 32'h0, {31'h0, irq});
    conv(12'h0d4);
    rd(sarc_pkg::OFS_RESULT, 32'h0000_00d4, 32'h0000_0fff);
    // overwrite policy with dma requests
    wr(sarc_pkg::OFS_CONFIG, 32'h0004_0006);
    d0 = n_dma;
    conv(12'h1e5);
    chk("dma", d0 + 1, n_dma);
    conv(12'h2f6);
    chk("dma", d0 + 1, n_dma);
    rd(sarc_pkg::OFS_RESULT, 32'h0000_02f6, 32'h0000_0fff);
    wr(sarc_pkg::OFS_STATUS, 32'h0000_0003);
    conv(12'h307);
    chk("dma", d0 + 2, n_dma);
    rd(sarc_pkg::OFS_RESULT, 32'h0000_0307, 32'h0000_0fff);
    // auto-wait holds off both trigger kinds until the read
    wr(sarc_pkg::OFS_CONFIG, 32'h0004_0008);
    conv(12'h418);
    c0 = n_conv;
    wr(sarc_pkg::OFS_CONTROL, 32'h0000_0001);
    pulse;
    repeat (40) @(posedge ref_clk_in);
    chk("conversions", c0, n_conv);
    rd(sarc_pkg::OFS_RESULT, 32'h0000_0418, 32'h0000_0fff);
    level <= 12'h529;
    pulse;
    wait_conv;
    rd(sarc_pkg::OFS_RESULT, 32'h0000_0529, 32'h0000_0fff);
    wr(sarc_pkg::OFS_CONFIG, 32'h0004_0011);
    chk("analog reset", 32'h0, n_arst);
    conv(12'h63a);
    chk("analog reset", 32'h1, n_arst);
    chk("sensor power", 32'h1, {31'h0, temp_pwr});
    rd(sarc_pkg::OFS_RESULT, 32'h0000_063a, 32'h0000_0fff);
    // watchdog on channel 5, channel 17 has no enable
    wr(sarc_pkg::OFS_CONFIG, 32'h0005_0000);
    wr(sarc_pkg::OFS_WATCH_CH, 32'h0002_0020);
    wr(sarc_pkg::OFS_WATCH_THR, 32'h0200_0100);
    wconv(12'h300, 1'h1);
    wconv(12'h0ff, 1'h1);
    wconv(12'h200, 1'h0);
    wr(sarc_pkg::OFS_CONFIG, 32'h0011_0000);
    wconv(12'h300, 1'h0);
    wr(sarc_pkg::OFS_CONFIG, 32'h0005_0000);
    level <= 12'h300;
    wr(sarc_pkg::OFS_CONTROL, 32'h0000_0001);
    wr(sarc_pkg::OFS_WATCH_THR, 32'h0200_0100);
    wait_conv;
    rd(sarc_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0004);
    rd(sarc_pkg::OFS_RESULT, 32'h0000_0300, 32'h0000_0fff);
    wconv(12'h300, 1'h1);
    results();
  end
endmodule : sarc_top_bench
